// [vdc_regs.sv]
/*
 * Control and configuration register bank of a serial video deserializer,
 * reached over the ancillary/control port (10-bit AD bus, port clock,
 * port select and read/write strobes), with the multi-function I/O port.
 * Assumes the video datapath supplies its event pulses on clk, and the
 * control port pins are asynchronous and sampled here.
 */
// How it works
// RULE1: new sync sets flag, held a line, retriggers
// RULE2: eav character clears new sync flag
// RULE3: eav and sav bits follow timing characters
// RULE4: lock bit only when locked and phase acquired
// RULE5: lock detect defaults to port bit four
// RULE6: pattern filter bit enables bar transition codes
// RULE7: dedither bits steer lsb and vblank dedithering
// RULE8: both dedither bits off after reset
// RULE9: external vclk turns clock input, bias pfd
// RULE10: trs detection only while sync detect set
// RULE11: lsb clip forces trs low bits zero
// RULE12: nrzi bit enables nrzi to nrz conversion
// RULE13: descramble bit enables standard descrambling
// RULE14: video control resets to 36h, software restores
// RULE15: oscillator gate low enables reference, resets enabled
// RULE16: crystal amplifier off at reset, external reference
// RULE17: pins map register bits, fixed power-on mapping
// RULE18: select bit five chooses input or output
// RULE19: low five select bits pick the function
// RULE20: output select code table with reserved codes
// RULE21: host writes address then data on clock
// RULE22: framing enable may come from a port pin
// RULE23: reserved codes drive zero, bad inputs ignored
`timescale 1ns/1ps
module vdc_regs (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	// control port pins
	input  wire logic        port_clk,
	input  wire logic        anc_or_ctrl_select,
	input  wire logic        rd_wr,
	input  wire logic [9:0]  ad_in,
	output logic      [9:0]  ad_out,
	output logic             ad_oe,
	// multi-function port pins
	input  wire logic [7:0]  mf_in,
	output logic      [7:0]  mf_out,
	output logic      [7:0]  mf_oe,
	// events from the video datapath
	input  wire logic        trs_new,
	input  wire logic        eav_seen,
	input  wire logic        sav_seen,
	input  wire logic        line_tick,
	input  wire logic        loop_locked,
	input  wire logic        phase_acquired,
	input  wire logic [31:0] status_in,
	// controls to the datapath
	output logic             trs_detect_enable,
	output logic             trs_low_bits_clear_enable,
	output logic             nrzi_enable,
	output logic             descramble_enable,
	output logic             pattern_edge_filter_enable,
	output logic             dedither_enable,
	output logic             vblank_dedither_enable,
	output logic             framing_enable,
	output logic             word_clock_is_input,
	output logic             bias_or_pfd_output,
	output logic             ref_osc_gate_n,
	output logic             internal_osc_amp_enable,
	output logic             lock_detect
);
	typedef enum logic [1:0] {VDC_IDLE, VDC_WDATA, VDC_READ} vdc_port_type;

	vdc_sel_if sif ();

	// pin synchronisers
	logic [12:0] meta_q, meta_d, sync_q, sync_d;
	logic        clk_last_q, clk_last_d;
	logic        port_edge;
	logic        s_port_clk, s_ctrl_n, s_rd;
	logic [9:0]  s_ad;

	// port sequencer
	vdc_port_type st_q, st_d;
	logic [9:0]  addr_q, addr_d;
	logic [9:0]  rdat_q, rdat_d;
	logic        oe_q, oe_d;
	logic        wr_en;
	logic [9:0]  wr_addr;
	logic [7:0]  wr_data;

	// registers
	logic [7:0]  vsi_q, vsi_d;
	logic [7:0]  vpc_q, vpc_d;
	logic [7:0]  rcc_q, rcc_d;
	logic [5:0]  sel_q [8];
	logic [5:0]  sel_d [8];

	// video status state
	logic        new_sync_q, new_sync_d, eav_q, eav_d, sav_q, sav_d;
	logic        lock_q, lock_d;
	logic [1:0]  hold_q, hold_d;

	function automatic logic is_pin_sel(input logic [9:0] a);
		return (a >= vdc_pkg::OFF_PORT_PIN0_SELECT) &&
			(a <= vdc_pkg::OFF_PORT_PIN7_SELECT);
	endfunction

	function automatic logic [2:0] pin_idx(input logic [9:0] a);
		logic [9:0] d;
		d = a - vdc_pkg::OFF_PORT_PIN0_SELECT;
		return d[2:0];
	endfunction

	// ---- synchroniser and port clock edge ----
	always_comb begin
		meta_d     = {port_clk, anc_or_ctrl_select, rd_wr, ad_in};
		sync_d     = meta_q;
		clk_last_d = sync_q[12];
	end

	assign s_port_clk = sync_q[12];
	assign s_ctrl_n   = sync_q[11];
	assign s_rd       = sync_q[10];
	assign s_ad       = sync_q[9:0];
	assign port_edge  = s_port_clk && !clk_last_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q     <= '0;
			sync_q     <= '0;
			clk_last_q <= 1'b0;
		end else if (ce) begin
			meta_q     <= meta_d;
			sync_q     <= sync_d;
			clk_last_q <= clk_last_d;
		end
	end

	// ---- control port: address phase then data phase ----
	always_comb begin
		st_d    = st_q;
		addr_d  = addr_q;
		rdat_d  = rdat_q;
		oe_d    = oe_q;
		wr_en   = 1'b0;
		wr_addr = addr_q;
		wr_data = s_ad[7:0];
		if (s_ctrl_n) begin
			st_d = VDC_IDLE;
			oe_d = 1'b0;
		end else if (port_edge) begin
			case (st_q)
				VDC_IDLE: begin
					addr_d = s_ad; // [RULE21]
					if (s_rd) begin
						st_d   = VDC_READ;
						rdat_d = {2'b00, read_mux(s_ad)};
						oe_d   = 1'b1;
					end else begin
						st_d = VDC_WDATA;
					end
				end
				VDC_WDATA: begin
					wr_en = 1'b1; // [RULE21]
					st_d  = VDC_IDLE;
				end
				VDC_READ: begin
					st_d = VDC_IDLE;
					oe_d = 1'b0;
				end
				default: begin
					st_d = VDC_IDLE;
					oe_d = 1'b0;
				end
			endcase
		end else if (st_q == VDC_READ && !s_rd) begin
			st_d = VDC_IDLE;
			oe_d = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q   <= VDC_IDLE;
			addr_q <= '0;
			rdat_q <= '0;
			oe_q   <= 1'b0;
		end else if (ce) begin
			st_q   <= st_d;
			addr_q <= addr_d;
			rdat_q <= rdat_d;
			oe_q   <= oe_d;
		end
	end

	assign ad_out = rdat_q;
	assign ad_oe  = oe_q;

	function automatic logic [7:0] read_mux(input logic [9:0] a);
		logic [7:0] r;
		r = 8'h00;
		if (a == vdc_pkg::OFF_VIDEO_STATUS_INFO) begin
			r = vsi_q;
			r[vdc_pkg::VSI_NEW_SYNC] = new_sync_q;
			r[vdc_pkg::VSI_EAV]  = eav_q;
			r[vdc_pkg::VSI_SAV]  = sav_q;
			r[vdc_pkg::VSI_LOCK] = lock_q;
		end else if (a == vdc_pkg::OFF_VIDEO_PATH_CONTROL) begin
			r = vpc_q;
		end else if (a == vdc_pkg::OFF_REF_CLOCK_CONTROL) begin
			r = rcc_q;
		end else if (is_pin_sel(a)) begin
			r = {2'b00, sel_q[pin_idx(a)]};
		end
		return r;
	endfunction

	// ---- register writes ----
	always_comb begin
		vsi_d = vsi_q;
		vpc_d = vpc_q;
		rcc_d = rcc_q;
		for (int i = 0; i < 8; i++) begin
			sel_d[i] = sel_q[i];
		end
		if (wr_en) begin
			if (wr_addr == vdc_pkg::OFF_VIDEO_STATUS_INFO) begin
				vsi_d = wr_data & vdc_pkg::VSI_RW_MASK;
			end else if (wr_addr == vdc_pkg::OFF_VIDEO_PATH_CONTROL) begin
				vpc_d = wr_data; // [RULE14]
			end else if (wr_addr == vdc_pkg::OFF_REF_CLOCK_CONTROL) begin
				rcc_d = wr_data;
			end else if (is_pin_sel(wr_addr)) begin
				sel_d[pin_idx(wr_addr)] = wr_data[5:0]; // [RULE19]
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vsi_q <= vdc_pkg::VSI_RESET; // [RULE8]
			vpc_q <= vdc_pkg::VPC_RESET; // [RULE14]
			rcc_q <= vdc_pkg::RCC_RESET; // [RULE15] [RULE16]
			for (int i = 0; i < 8; i++) begin
				sel_q[i] <= vdc_pkg::SEL_RESET[i]; // [RULE5] [RULE17]
			end
		end else if (ce) begin
			vsi_q <= vsi_d;
			vpc_q <= vpc_d;
			rcc_q <= rcc_d;
			for (int i = 0; i < 8; i++) begin
				sel_q[i] <= sel_d[i];
			end
		end
	end

	// ---- video status tracking ----
	always_comb begin
		new_sync_d = new_sync_q;
		hold_d = hold_q;
		eav_d  = eav_q;
		sav_d  = sav_q;
		lock_d = loop_locked && phase_acquired; // [RULE4]
		if (trs_detect_enable) begin // [RULE10]
			if (eav_seen) begin
				eav_d = 1'b1; // [RULE3]
				sav_d = 1'b0;
			end else if (sav_seen) begin
				sav_d = 1'b1; // [RULE3]
				eav_d = 1'b0;
			end
			if (new_sync_q && line_tick && hold_q != 2'h0) begin
				hold_d = hold_q - 2'h1;
			end
			if (new_sync_q && eav_seen && hold_q == 2'h0) begin
				new_sync_d = 1'b0; // [RULE2]
			end
			// a fresh character wins over the clearing eav
			if (trs_new) begin
				new_sync_d = 1'b1; // [RULE1]
				hold_d     = vdc_pkg::NEW_SYNC_HOLD_LINES;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			new_sync_q <= 1'b0;
			hold_q <= '0;
			eav_q  <= 1'b0;
			sav_q  <= 1'b0;
			lock_q <= 1'b0;
		end else if (ce) begin
			new_sync_q <= new_sync_d;
			hold_q <= hold_d;
			eav_q  <= eav_d;
			sav_q  <= sav_d;
			lock_q <= lock_d;
		end
	end

	// ---- multi-function port ----
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			sif.sel[i] = sel_q[i];
		end
		sif.status = status_in;
		sif.status[vdc_pkg::CODE_SAV]  = sav_q;
		sif.status[vdc_pkg::CODE_EAV]  = eav_q;
		sif.status[vdc_pkg::CODE_NEW_SYNC] = new_sync_q;
		sif.status[vdc_pkg::CODE_LOCK] = lock_q; // [RULE5]
	end

	vdc_pin_mux u_pin_mux (
		.clk     (clk),
		.rst_n   (rst_n),
		.ce      (ce),
		.pin_in  (mf_in),
		.pin_out (mf_out),
		.pin_oe  (mf_oe),
		.sif     (sif)
	);

	// ---- controls to the datapath ----
	assign trs_detect_enable          = vpc_q[vdc_pkg::VPC_SYNC_DET]; // [RULE10]
	assign trs_low_bits_clear_enable  = vpc_q[vdc_pkg::VPC_LSB_CLIP]; // [RULE11]
	assign nrzi_enable                = vpc_q[vdc_pkg::VPC_NRZI]; // [RULE12]
	assign descramble_enable          = vpc_q[vdc_pkg::VPC_DESCR]; // [RULE13]
	assign word_clock_is_input        = vpc_q[vdc_pkg::VPC_EXT_VCLK]; // [RULE9]
	assign bias_or_pfd_output         = vpc_q[vdc_pkg::VPC_EXT_VCLK]; // [RULE9]
	assign ref_osc_gate_n             = rcc_q[vdc_pkg::RCC_GATE_N]; // [RULE15]
	assign internal_osc_amp_enable    = rcc_q[vdc_pkg::RCC_OSC_AMP]; // [RULE16]
	assign vblank_dedither_enable     = vsi_q[vdc_pkg::VSI_VDEDIT_EN]; // [RULE7]
	assign lock_detect                = lock_q;

	// a pin mapped as input replaces the register bit
	assign pattern_edge_filter_enable = sif.in_hit[vdc_pkg::IN_PEF] ?
		sif.in_val[vdc_pkg::IN_PEF] : vsi_q[vdc_pkg::VSI_PEF_EN]; // [RULE6]
	assign dedither_enable = sif.in_hit[vdc_pkg::IN_DEDITH] ?
		sif.in_val[vdc_pkg::IN_DEDITH] : vsi_q[vdc_pkg::VSI_DEDITH_EN]; // [RULE7]
	assign framing_enable = sif.in_hit[vdc_pkg::IN_FRAME] ?
		sif.in_val[vdc_pkg::IN_FRAME] : vsi_q[vdc_pkg::VSI_FRAME_EN]; // [RULE22]
endmodule // vdc_regs

// [vdc_pkg.sv]
/*
 * Shared constants of the video deserializer control register bank:
 * register offsets, field positions, reset values and select codes.
 * Assumes a 10-bit control port, 8-bit registers and a 6-bit pin select.
 */
package vdc_pkg;
	localparam int unsigned ADDR_W    = 10;
	localparam int unsigned REG_W     = 8;
	localparam int unsigned PINS      = 8;
	localparam int unsigned SEL_W     = 6;

	// register offsets
	localparam logic [9:0] OFF_VIDEO_STATUS_INFO  = 10'h00E;
	localparam logic [9:0] OFF_PORT_PIN0_SELECT   = 10'h00F;
	localparam logic [9:0] OFF_PORT_PIN7_SELECT   = 10'h016;
	localparam logic [9:0] OFF_VIDEO_PATH_CONTROL = 10'h055;
	localparam logic [9:0] OFF_REF_CLOCK_CONTROL  = 10'h067;

	// video_status_info fields
	localparam int unsigned VSI_NEW_SYNC  = 0;
	localparam int unsigned VSI_EAV       = 1;
	localparam int unsigned VSI_SAV       = 2;
	localparam int unsigned VSI_LOCK      = 3;
	localparam int unsigned VSI_PEF_EN    = 4;
	localparam int unsigned VSI_DEDITH_EN = 5;
	localparam int unsigned VSI_VDEDIT_EN = 6;
	localparam int unsigned VSI_FRAME_EN  = 7;
	localparam logic [7:0]  VSI_RW_MASK   = 8'hF0;
	localparam logic [7:0]  VSI_RESET     = 8'h00;

	// video_path_control fields
	localparam int unsigned VPC_EXT_VCLK  = 0;
	localparam int unsigned VPC_SYNC_DET  = 1;
	localparam int unsigned VPC_LSB_CLIP  = 2;
	localparam int unsigned VPC_NRZI      = 4;
	localparam int unsigned VPC_DESCR     = 5;
	localparam logic [7:0]  VPC_RESET     = 8'h36;

	// reference_clock_control fields
	localparam int unsigned RCC_GATE_N    = 0;
	localparam int unsigned RCC_OSC_AMP   = 1;
	localparam logic [7:0]  RCC_RESET     = 8'h00;

	// pin select fields and power-on mapping
	localparam int unsigned SEL_DIR       = 5;
	localparam logic [5:0]  SEL_RESET [PINS] = '{
		6'h12, 6'h13, 6'h14, 6'h19, 6'h1C, 6'h04, 6'h1B, 6'h0E};

	// output select codes driven from this block
	localparam logic [4:0]  CODE_SAV      = 5'h0D;
	localparam logic [4:0]  CODE_EAV      = 5'h0E;
	localparam logic [4:0]  CODE_NEW_SYNC = 5'h0F;
	localparam logic [4:0]  CODE_LOCK     = 5'h1C;
	// input select codes, low four bits of 2Ch..2Eh
	localparam int unsigned IN_PEF        = 12;
	localparam int unsigned IN_DEDITH     = 13;
	localparam int unsigned IN_FRAME      = 14;

	// horizontal lines the new-sync flag is held at least
	localparam logic [1:0]  NEW_SYNC_HOLD_LINES = 2'h1;
endpackage

// [vdc_sel_if.sv]
/*
 * Carrier between the register bank and its pin mapper.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface vdc_sel_if;
	logic [5:0]  sel [8];
	logic [31:0] status;
	logic [15:0] in_val;
	logic [15:0] in_hit;

	modport regs (output sel, output status, input in_val, input in_hit);
	modport mapper (input sel, input status, output in_val, output in_hit);
endinterface

// [vdc_pin_mux.sv]
/*
 * Multi-function port mapper: each pin follows its select code, either
 * driving a chosen status bit or feeding a chosen control function.
 * Assumes pin inputs are asynchronous to clk.
 */
`timescale 1ns/1ps
module vdc_pin_mux (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic [7:0] pin_in,
	output logic      [7:0] pin_out,
	output logic      [7:0] pin_oe,
	vdc_sel_if.mapper       sif
);
	logic [7:0]  meta_q, sync_q, meta_d, sync_d;
	logic [7:0]  out_d, out_q, oe_d, oe_q;

	function automatic logic is_reserved(input logic [4:0] c);
		return (c == 5'h00) || (c == 5'h05) || (c == 5'h06) ||
			((c >= 5'h0A) && (c <= 5'h0C));
	endfunction

	always_comb begin
		meta_d = pin_in;
		sync_d = meta_q;
		sif.in_val = '0;
		sif.in_hit = '0;
		for (int i = 0; i < 8; i++) begin
			out_d[i] = 1'b0;
			oe_d[i]  = 1'b0;
			if (!sif.sel[i][vdc_pkg::SEL_DIR]) begin // [RULE18]
				oe_d[i] = 1'b1;
				if (!is_reserved(sif.sel[i][4:0])) begin // [RULE23]
					out_d[i] = sif.status[sif.sel[i][4:0]]; // [RULE17] [RULE20]
				end
			end else if (!sif.sel[i][4]) begin // [RULE19]
				sif.in_hit[sif.sel[i][3:0]] = 1'b1;
				sif.in_val[sif.sel[i][3:0]] = sync_q[i];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_q <= '0;
			out_q  <= '0;
			oe_q   <= '0;
		end else if (ce) begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			out_q  <= out_d;
			oe_q   <= oe_d;
		end
	end

	assign pin_out = out_q;
	assign pin_oe  = oe_q;
endmodule // vdc_pin_mux

// [vdc_regs_props.sv]
/* Assertions on the register bank ports.
   Assumes ce high and pins 4 and 7 keep their power-on codes. */
`timescale 1ns/1ps
module vdc_regs_props (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       rd_wr,
	input wire logic       ad_oe,
	input wire logic [7:0] mf_out,
	input wire logic       eav_seen,
	input wire logic       sav_seen,
	input wire logic       loop_locked,
	input wire logic       phase_acquired,
	input wire logic       lock_detect,
	input wire logic       trs_detect_enable,
	input wire logic       dedither_enable,
	input wire logic       vblank_dedither_enable,
	input wire logic       word_clock_is_input,
	input wire logic       bias_or_pfd_output,
	input wire logic       ref_osc_gate_n,
	input wire logic       internal_osc_amp_enable
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_lock_level: assert property (
		lock_detect == ($past(loop_locked) && $past(phase_acquired)))
		else $error("lock detect off its cause");
	a_lock_pin: assert property (
		mf_out[4] == $past(lock_detect))
		else $error("pin 4 not lock detect");
	a_vclk_pair: assert property (
		word_clock_is_input == bias_or_pfd_output)
		else $error("vclk and bias outputs differ");
	a_dedither_reset: assert property (
		$rose(rst_n) |-> !dedither_enable && !vblank_dedither_enable)
		else $error("dedither on after reset");
	a_refclk_reset: assert property (
		$rose(rst_n) |-> !ref_osc_gate_n && !internal_osc_amp_enable)
		else $error("reference clock bits wrong after reset");
	a_ctrl_reset: assert property (
		$rose(rst_n) |-> trs_detect_enable && !word_clock_is_input)
		else $error("video control wrong after reset");
	a_eav_pin: assert property (
		trs_detect_enable && eav_seen && !sav_seen |-> ##2 mf_out[7])
		else $error("eav not on pin 7");
	a_sync_gate: assert property (
		!trs_detect_enable [*3] |-> $stable(mf_out[7]))
		else $error("timing event taken with detection off");
	a_write_quiet: assert property (
		!rd_wr [*5] |-> !ad_oe)
		else $error("bus driven during write");

	c_read: cover property ($rose(ad_oe));
	c_lock: cover property ($rose(lock_detect));
	c_eav: cover property (eav_seen ##2 mf_out[7]);
endmodule // vdc_regs_props

bind vdc_regs vdc_regs_props i_props (.clk(clk), .rst_n(rst_n),
	.rd_wr(rd_wr), .ad_oe(ad_oe), .mf_out(mf_out), .eav_seen(eav_seen),
	.sav_seen(sav_seen), .loop_locked(loop_locked),
	.phase_acquired(phase_acquired), .lock_detect(lock_detect),
	.trs_detect_enable(trs_detect_enable),
	.dedither_enable(dedither_enable),
	.vblank_dedither_enable(vblank_dedither_enable),
	.word_clock_is_input(word_clock_is_input),
	.bias_or_pfd_output(bias_or_pfd_output),
	.ref_osc_gate_n(ref_osc_gate_n),
	.internal_osc_amp_enable(internal_osc_amp_enable));

// [vdc_host.sv]
/* Host model of the control port: 800 ns port clock, still between
   accesses. Assumes the bench resolves the shared AD bus. */
`timescale 1ns/1ps
module vdc_host (
	input  wire logic       clk,
	input  wire logic [9:0] ad_out,
	input  wire logic       ad_oe,
	output logic            port_clk,
	output logic            anc_or_ctrl_select,
	output logic            rd_wr,
	output logic      [9:0] ad_drv,
	output logic            ad_en
);
	initial begin
		port_clk = 1'h0;
		anc_or_ctrl_select = 1'h1;
		rd_wr = 1'h1;
		ad_drv = 10'h000;
		ad_en = 1'h0;
	end
	task automatic half(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic tick();
		half(4);
		port_clk = 1'h1;
		half(4);
		port_clk = 1'h0;
	endtask
	// select low, direction and address held over the address rise
	task automatic start(input logic [9:0] a, input logic rd);
		anc_or_ctrl_select = 1'h0;
		rd_wr = rd;
		ad_drv = a;
		ad_en = 1'h1;
	endtask
	task automatic stop();
		anc_or_ctrl_select = 1'h1;
		rd_wr = 1'h1;
		ad_en = 1'h0;
		half(8);
	endtask
	// address word on first rise, data word on second
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		start(a, 1'h0);
		tick();
		ad_drv = {2'h0, d};
		tick();
		stop();
	endtask
	// bus released once the address is taken, data caught while high
	task automatic rd(input logic [9:0] a, output logic [10:0] r);
		start(a, 1'h1);
		half(4);
		port_clk = 1'h1;
		half(4);
		ad_en = 1'h0;
		half(2);
		r = {ad_oe, ad_out};
		port_clk = 1'h0;
		tick();
		stop();
	endtask
endmodule // vdc_host

// [testbench.sv]
/* Bench for the register bank: reset values, control bits, pin
   mapping and video events. Assumes the host model and checker. */
`timescale 1ns/1ps
module testbench;
	logic        clk;
	logic        rst_n;
	logic        port_clk;
	logic        anc_or_ctrl_select;
	logic        rd_wr;
	logic [9:0]  ad_drv;
	logic        ad_en;
	logic [9:0]  ad_out;
	logic        ad_oe;
	logic [7:0]  mf_drv;
	logic [7:0]  mf_out;
	logic [7:0]  mf_oe;
	logic [3:0]  evt;
	logic        loop_locked;
	logic        phase_acquired;
	logic [31:0] status_in;
	wire  [12:0] ctl;
	logic [10:0] rv;
	int          checks;
	int          mismatches;
	wire  [9:0]  ad_w = ad_oe ? ad_out : (ad_en ? ad_drv : ~ad_drv);
	wire  [7:0]  mf_w = (mf_oe & mf_out) | (~mf_oe & mf_drv);

	vdc_host i_host (.clk(clk), .ad_out(ad_out), .ad_oe(ad_oe),
		.port_clk(port_clk), .anc_or_ctrl_select(anc_or_ctrl_select),
		.rd_wr(rd_wr), .ad_drv(ad_drv), .ad_en(ad_en));
	vdc_regs i_dut (.clk(clk), .rst_n(rst_n), .ce(1'h1),
		.port_clk(port_clk), .anc_or_ctrl_select(anc_or_ctrl_select),
		.rd_wr(rd_wr), .ad_in(ad_w), .ad_out(ad_out), .ad_oe(ad_oe),
		.mf_in(mf_w), .mf_out(mf_out), .mf_oe(mf_oe),
		.trs_new(evt[0]), .eav_seen(evt[1]), .sav_seen(evt[2]),
		.line_tick(evt[3]), .loop_locked(loop_locked),
		.phase_acquired(phase_acquired), .status_in(status_in),
		.trs_detect_enable(ctl[0]), .trs_low_bits_clear_enable(ctl[1]),
		.nrzi_enable(ctl[2]), .descramble_enable(ctl[3]),
		.pattern_edge_filter_enable(ctl[4]), .dedither_enable(ctl[5]),
		.vblank_dedither_enable(ctl[6]), .framing_enable(ctl[7]),
		.word_clock_is_input(ctl[8]), .bias_or_pfd_output(ctl[9]),
		.ref_osc_gate_n(ctl[10]), .internal_osc_amp_enable(ctl[11]),
		.lock_detect(ctl[12]));

	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	// about three times the expected run of some 1300 cycles
	initial begin
		#400000;
		mismatches++;
		print_verdict();
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, g);
		checks++;
		if (g !== e) begin
			$display("unexpected %s exp %h got %h", n, e, g);
			mismatches++;
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic rdc(input logic [9:0] a, input logic [7:0] e);
		i_host.rd(a, rv);
		chk("read data", {5'h00, 1'h1, 2'h0, e}, {5'h00, rv});
	endtask
	task automatic ev(input int k);
		evt[k] = 1'h1;
		wt(1);
		evt[k] = 1'h0;
		wt(3);
	endtask
	task automatic t_reset();
		rdc(10'h00E, 8'h00); // status reset
		rdc(10'h055, 8'h36); // control reset
		rdc(10'h067, 8'h00); // clock reset
		for (int i = 0; i < 8; i++) begin
			rdc(10'(15 + i), {2'h0, vdc_pkg::SEL_RESET[i]}); // map
		end
		rdc(10'h100, 8'h00); // unmapped place
		chk("ctl", 16'h000F, {3'h0, ctl}); // outputs
		chk("mf_oe", 16'h00FF, {8'h00, mf_oe}); // all out
		$display("test reset done");
	endtask
	task automatic t_ctrl();
		i_host.wr(10'h055, 8'h01);
		chk("ctl", 16'h0300, {3'h0, ctl}); // bits
		ev(1);
		chk("pin7", 16'h0, {15'h0, mf_out[7]}); // eav ignored
		i_host.wr(10'h055, 8'h36);
		chk("ctl", 16'h000F, {3'h0, ctl}); // restored
		i_host.wr(10'h067, 8'h03);
		chk("ctl", 16'h0C0F, {3'h0, ctl}); // clock bits
		rdc(10'h067, 8'h03); // read back
		i_host.wr(10'h067, 8'h00);
		i_host.wr(10'h00E, 8'hFF);
		chk("ctl", 16'h00FF, {3'h0, ctl}); // enables
		rdc(10'h00E, 8'hF0); // status bits kept
		i_host.wr(10'h00E, 8'h00);
		chk("ctl", 16'h000F, {3'h0, ctl}); // enables off
		$display("test control done");
	endtask
	task automatic t_events();
		i_host.wr(10'h012, 8'h0F);
		ev(0);
		chk("new sync", 16'h1, {15'h0, mf_out[3]}); // set
		ev(1);
		chk("new sync", 16'h1, {15'h0, mf_out[3]}); // held a line
		ev(3);
		ev(0);
		ev(1);
		chk("new sync", 16'h1, {15'h0, mf_out[3]}); // retriggered
		ev(3);
		ev(1);
		chk("new sync eav", 16'h1, {14'h0, mf_out[3], mf_out[7]});
		ev(2);
		chk("eav", 16'h0, {15'h0, mf_out[7]}); // sav clears
		loop_locked = 1'h1;
		wt(3);
		chk("lock", 16'h0, {15'h0, ctl[12]}); // no phase
		phase_acquired = 1'h1;
		wt(3);
		chk("lock", 16'h3, {14'h0, ctl[12], mf_out[4]});
		rdc(10'h00E, 8'h0C); // sav and lock
		loop_locked = 1'h0;
		i_host.wr(10'h012, 8'h19);
		$display("test events done");
	endtask
	task automatic t_pins();
		for (int k = 0; k < 3; k++) begin
			i_host.wr(10'h00F, 8'h2C + 8'(k));
			mf_drv = 8'h01;
			wt(4);
			chk("pin in", 16'h1, {14'h0, mf_oe[0], ctl[k == 2 ? 7 : 4 + k]});
			mf_drv = 8'h00;
			wt(4);
			chk("pin in", 16'h0, {15'h0, ctl[k == 2 ? 7 : 4 + k]});
		end
		i_host.wr(10'h00F, 8'h3C);
		mf_drv = 8'h01;
		wt(4);
		chk("ctl", 16'h000F, {3'h0, ctl}); // code ignored
		for (int c = 1; c < 23; c++) begin
			logic rsv;
			rsv = (c == 5) || (c == 6) || (c > 9 && c < 13);
			if (c > 12 && c < 16) continue;
			status_in = rsv ? 32'hFFFFFFFF : 32'h1 << c;
			i_host.wr(10'h00F, 8'(c));
			chk("pin out", {14'h0, 1'h1, !rsv}, {14'h0, mf_oe[0], mf_out[0]});
		end
		status_in = 32'h0;
		mf_drv = 8'h00;
		i_host.wr(10'h00F, 8'h12);
		$display("test pins done");
	endtask

	initial begin
		rst_n = 1'h0;
		status_in = 32'h0;
		evt = 4'h0;
		loop_locked = 1'h0;
		phase_acquired = 1'h0;
		mf_drv = 8'h00;
		checks = 0;
		mismatches = 0;
		wt(6);
		rst_n = 1'h1;
		wt(2);
		t_reset();
		t_ctrl();
		t_events();
		t_pins();
		print_verdict();
	end
endmodule // testbench
